// ---- rtl/qio_expander.sv ----
// I2C slave engine with quasi-bidirectional port latch and change alert
`timescale 1ns/1ns
module qio_expander
	import qio_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = ADDR_DEFAULT
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic reset_hw_n,
	// I2C lines (open drain, data oe high while pulling low)
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Port pins (oe high while sinking low)
	input wire logic [7:0] port_pin_in,
	output logic [7:0] port_pin_out,
	output logic [7:0] port_pin_oe,
	// Change alert, active low level
	output logic alert_n
);
	// ----------------------------------------
	// Line decode
	// ----------------------------------------
	logic scl_lvl, scl_rise, scl_fall;
	logic sda_lvl, sda_rise, sda_fall;

	qio_edge_sync u_scl (
		.clk_sys(clk_sys),
		.reset(reset),
		.line_in(scl_in),
		.level(scl_lvl),
		.rise(scl_rise),
		.fall(scl_fall)
	);

	qio_edge_sync u_sda (
		.clk_sys(clk_sys),
		.reset(reset),
		.line_in(sda_in),
		.level(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// Start and stop seen while the clock stays high
	wire start_det = sda_fall & scl_lvl & ~scl_rise;
	wire stop_det = sda_rise & scl_lvl & ~scl_rise;
	wire hold_rst = reset | ~reset_hw_n;

	// ----------------------------------------
	// State
	// ----------------------------------------
	bus_state_e state_ff, nxt_state;
	logic [2:0] bit_ff; // Bit index within the byte
	logic [7:0] shift_ff; // Receive and transmit shift register
	logic [7:0] latch_ff; // Port latch
	logic [7:0] ref_ff; // Pin levels at last read or write
	logic sda_drv_ff; // High while pulling data low
	logic ack_seen_ff; // Master acknowledged the last sent byte
	logic upd_ff; // One-cycle pulse: latch or read took place
	// Low from a start until the first rising clock of the address byte
	logic armed_ff;

	wire byte_done = (bit_ff == LAST_BIT);
	wire addr_hit = (shift_ff[7:1] == SLAVE_ADDR);
	wire is_read = (shift_ff[RW_BIT] == RW_READ);

	// ----------------------------------------
	// Next-state decode on falling clock edges
	// ----------------------------------------
	// Moves happen on the falling edge so data changes only while clock is low
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: nxt_state = ST_IDLE;
			ST_ADDR: begin
				if (byte_done) begin
					nxt_state = addr_hit ? ST_ACK_ADDR : ST_IDLE;
				end
			end
			ST_ACK_ADDR: nxt_state = is_read ? ST_TX : ST_RX;
			ST_RX: begin
				if (byte_done) begin
					nxt_state = ST_ACK_RX;
				end
			end
			ST_ACK_RX: nxt_state = ST_RX;
			ST_TX: begin
				if (byte_done) begin
					nxt_state = ST_ACK_TX;
				end
			end
			ST_ACK_TX: nxt_state = ack_seen_ff ? ST_TX : ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// Bus engine
	// ----------------------------------------
	// Sample on rising clock, shift out and advance on falling clock
	always_ff @(posedge clk_sys) begin
		if (hold_rst) begin
			state_ff <= ST_IDLE;
			bit_ff <= 3'h0;
			shift_ff <= 8'h00;
			sda_drv_ff <= 1'b0;
			ack_seen_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else if (start_det) begin
			// Repeated start is accepted anywhere
			state_ff <= ST_ADDR;
			bit_ff <= 3'h0;
			sda_drv_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= ST_IDLE;
			sda_drv_ff <= 1'b0;
		end else if (scl_rise) begin
			armed_ff <= 1'b1;
			if (state_ff == ST_ADDR || state_ff == ST_RX) begin
				shift_ff <= {shift_ff[6:0], sda_lvl};
			end
			if (state_ff == ST_ACK_TX) begin
				ack_seen_ff <= ~sda_lvl;
			end
		end else if (scl_fall && armed_ff) begin
			// The clock fall that closes a start carries no bit; counting it
			// would end the address byte one bit early
			state_ff <= nxt_state;
			bit_ff <= (state_ff == ST_ADDR || state_ff == ST_RX || state_ff == ST_TX)
				? bit_ff + 3'h1 : 3'h0;
			case (nxt_state)
				ST_ACK_ADDR, ST_ACK_RX: sda_drv_ff <= 1'b1;
				ST_TX: begin
					if (state_ff == ST_TX) begin
						sda_drv_ff <= ~shift_ff[6];
						shift_ff <= {shift_ff[6:0], 1'b1};
					end else begin
						// Capture pins at the start of each read byte
						sda_drv_ff <= ~port_pin_in[7];
						shift_ff <= port_pin_in;
					end
				end
				default: sda_drv_ff <= 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// Port latch and alert reference
	// ----------------------------------------
	// Latch loads at the end of the acknowledge slot of a received data byte
	wire latch_load = scl_fall & (state_ff == ST_ACK_RX) & ~start_det & ~stop_det;
	wire read_take = scl_fall & (state_ff == ST_ACK_ADDR || state_ff == ST_ACK_TX)
		& (nxt_state == ST_TX) & ~start_det & ~stop_det;

	always_ff @(posedge clk_sys) begin
		if (hold_rst) begin
			latch_ff <= LATCH_RESET;
			ref_ff <= LATCH_RESET;
			upd_ff <= 1'b0;
		end else begin
			upd_ff <= latch_load | read_take;
			if (latch_load) begin
				latch_ff <= shift_ff;
			end
			if (read_take) begin
				ref_ff <= port_pin_in;
			end else if (upd_ff) begin
				// Pins settle one cycle after a write, so take them then
				ref_ff <= port_pin_in;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sda_out = 1'b0;
	assign sda_oe = sda_drv_ff;
	assign port_pin_out = 8'h00;
	assign port_pin_oe = ~latch_ff;
	// Alert follows any pin differing from its reference, held high in the cycle after a latch or read; no latency filter
	assign alert_n = (port_pin_in == ref_ff) | upd_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	addr_ack_drive_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && state_ff == ST_ADDR && byte_done && addr_hit && !start_det && !stop_det
		|=> sda_oe) else $error("address ack not driven");
	data_ack_drive_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && state_ff == ST_RX && byte_done && !start_det && !stop_det
		|=> sda_oe && state_ff == ST_ACK_RX) else $error("data ack not driven");
	ack_stable_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		(state_ff == ST_ACK_RX) && scl_rise && !stop_det |=> sda_oe)
		else $error("ack dropped in clock high");
	nack_release_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && state_ff == ST_ACK_TX && !ack_seen_ff && !start_det && !stop_det
		|=> !sda_oe && state_ff == ST_IDLE) else $error("data not released");
	miss_ignore_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && state_ff == ST_ADDR && byte_done && !addr_hit && !start_det && !stop_det
		|=> !sda_oe && state_ff == ST_IDLE) else $error("foreign address served");
	latch_load_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		latch_load |=> port_pin_oe == ~$past(shift_ff)) else $error("latch not loaded");
	read_value_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		read_take |=> shift_ff == $past(port_pin_in)) else $error("read value wrong");
	alert_clear_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		read_take |=> alert_n) else $error("alert not cleared by read");
	alert_set_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		!upd_ff && port_pin_in != ref_ff |-> !alert_n) else $error("alert missed");
	dir_select_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && state_ff == ST_ACK_ADDR && !start_det && !stop_det
		|=> state_ff == ($past(is_read) ? ST_TX : ST_RX)) else $error("direction wrong");
	// Master owns the data line in the acknowledge slot of a sent byte
	tx_release_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && armed_ff && state_ff == ST_TX && byte_done && !start_det && !stop_det
		|=> !sda_oe && state_ff == ST_ACK_TX) else $error("data not released for master ack");
	// The fall that closes a start leaves the bit count alone
	start_fall_a: assert property (@(posedge clk_sys) disable iff (hold_rst)
		scl_fall && !armed_ff && !start_det && !stop_det
		|=> bit_ff == 3'h0 && state_ff == $past(state_ff)) else $error("start fall counted");
endmodule

// ---- pkg/qio_pkg.sv ----
// Constants for the I2C quasi-bidirectional eight-pin port expander
package qio_pkg;
	// ----------------------------------------
	// Sizes and defaults
	// ----------------------------------------
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned BYTE_BITS = 8;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [7:0] LATCH_RESET = 8'hff;
	localparam int unsigned ADDR_WIDTH = 7;
	localparam logic [6:0] ADDR_DEFAULT = 7'h20;
	localparam int unsigned RW_BIT = 0;
	localparam logic RW_READ = 1'b1;
	// Bus engine states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ACK_ADDR,
		ST_RX,
		ST_ACK_RX,
		ST_TX,
		ST_ACK_TX
	} bus_state_e;
endpackage

// ---- rtl/qio_edge_sync.sv ----
// Edge detector for the sampled serial clock and data lines
`timescale 1ns/1ns
module qio_edge_sync
	import qio_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Line input
	input wire logic line_in,
	// Decoded line
	output logic level,
	output logic rise,
	output logic fall
);
	// ----------------------------------------
	// Previous level
	// ----------------------------------------
	logic prev_ff; // Last sampled level, reset high like an idle bus

	// Inputs are synchronous, so one stage suffices
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			prev_ff <= 1'b1;
		end else begin
			prev_ff <= line_in;
		end
	end

	assign level = line_in;
	assign rise = line_in & ~prev_ff;
	assign fall = ~line_in & prev_ff;
endmodule

// ---- test/i2c_host_model.sv ----
// Behavioural I2C bus master for the port expander
`timescale 1ns/1ns
module i2c_host_model (
	// Clock
	input wire logic clk_sys,
	// Serial lines
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_pull
);
	// Idle bus: clock high, data released to the pull-up
	initial begin
		scl_out = 1'b1;
		sda_pull = 1'b0;
	end
	// Four clocks per phase, well above the two-clock minimum
	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask
	// Start, also repeated start from a low clock
	task automatic start();
		sda_pull = 1'b0;
		half();
		scl_out = 1'b1;
		half();
		sda_pull = 1'b1;
		half();
		scl_out = 1'b0;
	endtask
	// Stop: data low, clock high, then data released
	task automatic stop();
		sda_pull = 1'b1;
		half();
		scl_out = 1'b1;
		half();
		sda_pull = 1'b0;
		half();
	endtask
	// One bit slot; data is held through the clock-high phase
	task automatic bit_slot(input logic b, output logic r);
		sda_pull = ~b;
		half();
		scl_out = 1'b1;
		repeat (2) @(negedge clk_sys);
		r = sda_in;
		repeat (2) @(negedge clk_sys);
		scl_out = 1'b0;
	endtask
	// Eight bits MSB first, then one acknowledge slot
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
		output logic a_seen);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], b);
			q[i] = b;
		end
		bit_slot(a, a_seen); // Low to go on, high ends a read
	endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the I2C port expander
`timescale 1ns/1ns
module tb;
	import qio_pkg::*;
	// ----------------------------------------
	// Signals and instances
	// ----------------------------------------
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic reset_hw_n = 1'b1;
	logic [7:0] ext_low = 8'h00; // External pull-downs on the pins
	logic scl, m_pull, sda_oe, sda_out, alert_n, ack;
	logic [7:0] pin_oe, pin_out, q;
	int num_errors = 0;
	int total_checks = 0;
	// Open-drain lines read low when any party pulls
	wire logic sda = ~(sda_oe | m_pull);
	wire logic [7:0] pins = ~(pin_oe | ext_low);
	always #2 clk_sys = ~clk_sys;
	qio_expander dut_u (.clk_sys(clk_sys), .reset(reset), .reset_hw_n(reset_hw_n),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.port_pin_in(pins), .port_pin_out(pin_out), .port_pin_oe(pin_oe),
		.alert_n(alert_n));
	i2c_host_model host_u (.clk_sys(clk_sys), .sda_in(sda), .scl_out(scl),
		.sda_pull(m_pull));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic addr(input logic [6:0] a, input logic rw);
		host_u.start();
		host_u.xfer({a, rw}, 1'b1, q, ack);
	endtask
	task automatic complete_run();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_write();
		logic [7:0] w [2];
		w = '{8'ha3, 8'h2b}; // Bits 1:0 stay one for the input pins
		addr(ADDR_DEFAULT, 1'b0);
		chk({7'h0, ack}, 8'h00);
		for (int i = 0; i < 2; i++) begin
			host_u.xfer(w[i], 1'b1, q, ack);
			chk({7'h0, ack}, 8'h00);
			wait_clk(4);
			chk(pin_oe, ~w[i]);
		end
		chk({7'h0, alert_n}, 8'h01);
		host_u.stop();
		$display("test write done");
	endtask
	task automatic t_alert();
		ext_low = 8'h01;
		wait_clk(4);
		chk({7'h0, alert_n}, 8'h00);
		ext_low = 8'h00;
		wait_clk(4);
		chk({7'h0, alert_n}, 8'h01);
		ext_low = 8'h01;
		wait_clk(4);
		chk({7'h0, alert_n}, 8'h00);
		$display("test alert done");
	endtask
	task automatic t_read();
		addr(ADDR_DEFAULT, 1'b1);
		chk({7'h0, ack}, 8'h00);
		host_u.xfer(8'hff, 1'b0, q, ack);
		chk(q, 8'h2a);
		chk({7'h0, alert_n}, 8'h01);
		ext_low = 8'h03;
		host_u.xfer(8'hff, 1'b1, q, ack);
		chk(q, 8'h28);
		wait_clk(2);
		chk({7'h0, sda_oe}, 8'h00);
		host_u.stop();
		ext_low = 8'h00;
		$display("test read done");
	endtask
	task automatic t_miss();
		addr(ADDR_DEFAULT ^ 7'h01, 1'b0);
		chk({7'h0, ack}, 8'h01);
		host_u.xfer(8'h00, 1'b1, q, ack);
		chk({7'h0, ack}, 8'h01);
		chk(pin_oe, 8'hd4);
		chk({7'h0, alert_n}, 8'h00);
		host_u.stop();
		$display("test miss done");
	endtask
	task automatic t_restart();
		addr(ADDR_DEFAULT, 1'b0);
		chk({7'h0, ack}, 8'h00);
		host_u.xfer(8'h2b, 1'b1, q, ack);
		wait_clk(4);
		chk({7'h0, alert_n}, 8'h01);
		addr(ADDR_DEFAULT, 1'b1); // Repeated start, no stop in between
		chk({7'h0, ack}, 8'h00);
		host_u.xfer(8'hff, 1'b1, q, ack);
		chk(q, 8'h2b);
		wait_clk(2);
		chk({7'h0, sda_oe}, 8'h00);
		host_u.stop();
		$display("test restart done");
	endtask
	task automatic t_hw();
		reset_hw_n = 1'b0;
		wait_clk(2);
		chk(pin_oe, 8'h00);
		reset_hw_n = 1'b1;
		wait_clk(2);
		chk(pin_oe, 8'h00);
		chk({7'h0, sda_oe}, 8'h00);
		chk({7'h0, alert_n}, 8'h01);
		chk(pin_out, 8'h00);
		chk({7'h0, sda_out}, 8'h00);
		$display("test hw reset done");
	endtask
	// Main sequence after twenty reset cycles
	initial begin
		wait_clk(20);
		reset = 1'b0;
		wait_clk(2);
		chk(pin_oe, 8'h00);
		chk({7'h0, alert_n}, 8'h01);
		t_write();
		t_alert();
		t_read();
		t_miss();
		t_restart();
		t_hw();
		complete_run();
	end
	// Watchdog, about nineteen times the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		complete_run();
	end
endmodule
